// ---- core/gtm_timer.v ----
/*
 * Dual-half general timer: 32-bit one-shot/periodic, 32-bit RTC,
 * and per half 16-bit one-shot/periodic, edge count, edge time, PWM.
 * Assumes pins may be asynchronous inputs, one clock, a strobe register
 * port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "gtm_consts.vh"

// Contract
// - Edge-time half free-runs down from load
// - Edge-time mode ignores the prescaler
// - Edge time needs capture select, mode 3
// - Keeps counting, reloads at zero
// - Captured count held until next edge
// - Edge-time load write applies next cycle
// - PWM needs alt select, no capture, mode 2
// - PWM counts to zero, reloads, repeats
// - PWM half raises no status flags
// - PWM on at load, off at match
// - Invert bit complements the PWM output
// - PWM load write applies next cycle
// - Config selects 32-bit, RTC, dual 16-bit
// - Mode 1 one-shot, mode 2 periodic
// - One-shot stops, periodic keeps running
// - Writing one clears a status flag
// - RTC match rolls over to zero
// - Edge count needs no capture, mode 3
// - Edge count stops after programmed edges
// - Each selected edge before the match decrements by one
// - RTC override keeps counter from stalling
module gtm_timer #(
    parameter RTC_DIV = `GTM_RTC_DIV
) (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register port
    input wire [7:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [31:0] bus_rdata,
    // Capture/compare pins and debug halt
    input wire ccp_a,
    input wire ccp_b,
    input wire debug_halt,
    // PWM outputs
    output reg pwm_a,
    output reg pwm_b
);

localparam [15:0] RTC_LAST = RTC_DIV[15:0] - 16'h0001;

////////////////////////////////////////////////////////////////////////
// Functions

// Decode one half's mode register into the kind of operation
function [2:0] half_kind;
    input [3:0] mr;
    begin
        half_kind = `GTM_K_NONE;
        if (mr[`GTM_MR_AMS] && !mr[`GTM_MR_CMR] &&
                mr[1:0] == `GTM_MR_PERIODIC) begin
            half_kind = `GTM_K_PWM;
        end else if (!mr[`GTM_MR_AMS] &&
                mr[1:0] == `GTM_MR_CAPTURE) begin
            half_kind = mr[`GTM_MR_CMR] ? `GTM_K_ETIME : `GTM_K_ECNT;
        end else if (!mr[`GTM_MR_AMS] &&
                (mr[1:0] == `GTM_MR_ONESHOT ||
                 mr[1:0] == `GTM_MR_PERIODIC)) begin
            half_kind = `GTM_K_TIMER;
        end
    end
endfunction

// Selected edge seen on a synchronised pin
function edge_hit;
    input [1:0] evt;
    input cur;
    input old;
    begin
        case (evt)
            `GTM_EV_RISE: edge_hit = cur & ~old;
            `GTM_EV_FALL: edge_hit = ~cur & old;
            `GTM_EV_BOTH: edge_hit = cur ^ old;
            default: edge_hit = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// State

reg [2:0] cfg_reg, cfg_next;
reg [15:0] ctl_reg, ctl_next;
reg [15:0] imr_reg, imr_next;
reg [15:0] ris_reg, ris_next;
reg [3:0] mode_reg [0:1];
reg [3:0] mode_next [0:1];
reg [15:0] ilr_reg [0:1];
reg [15:0] ilr_next [0:1];
reg [15:0] mat_reg [0:1];
reg [15:0] mat_next [0:1];
reg [15:0] cnt_reg [0:1];
reg [15:0] cnt_next [0:1];
reg [15:0] cap_reg [0:1];
reg [15:0] cap_next [0:1];
reg [7:0] pr_reg [0:1];
reg [7:0] pr_next [0:1];
reg [7:0] pmr_reg [0:1];
reg [7:0] pmr_next [0:1];
reg [7:0] ps_reg [0:1];
reg [7:0] ps_next [0:1];
reg [15:0] ilr_hi_reg, ilr_hi_next;
reg [15:0] mat_hi_reg, mat_hi_next;
reg [15:0] cnt_hi_reg, cnt_hi_next;
reg [15:0] rdiv_reg, rdiv_next;
reg [1:0] ld_reg, ld_next;
reg [1:0] lvl_reg, lvl_next;
reg [1:0] sync1_reg, sync2_reg, sync3_reg;
reg [31:0] rdata_next;
reg [15:0] st_set, st_clr;
reg [31:0] wide_cnt, wide_ilr, wide_mat;
reg [2:0] kind;
reg [1:0] edge_seen;
reg en, stall, tick, freeze;
integer hc, hs;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

always @(posedge clock) begin
    if (reset) begin
        sync1_reg <= 2'h0;
        sync2_reg <= 2'h0;
        sync3_reg <= 2'h0;
    end else begin
        sync1_reg <= {ccp_b, ccp_a};
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// Next-state logic

always @* begin
    cfg_next = cfg_reg;
    ctl_next = ctl_reg;
    imr_next = imr_reg;
    ilr_hi_next = ilr_hi_reg;
    mat_hi_next = mat_hi_reg;
    cnt_hi_next = cnt_hi_reg;
    rdiv_next = rdiv_reg;
    ld_next = 2'h0;
    lvl_next = 2'h0;
    st_set = 16'h0000;
    st_clr = 16'h0000;
    rdata_next = 32'h00000000;
    kind = `GTM_K_NONE;
    edge_seen = 2'h0;
    en = 1'b0;
    stall = 1'b0;
    tick = 1'b0;
    freeze = 1'b0;
    wide_cnt = {cnt_hi_reg, cnt_reg[0]};
    wide_ilr = {ilr_hi_reg, ilr_reg[0]};
    wide_mat = {mat_hi_reg, mat_reg[0]};
    for (hc = 0; hc < 2; hc = hc + 1) begin
        mode_next[hc] = mode_reg[hc];
        ilr_next[hc] = ilr_reg[hc];
        mat_next[hc] = mat_reg[hc];
        cnt_next[hc] = cnt_reg[hc];
        cap_next[hc] = cap_reg[hc];
        pr_next[hc] = pr_reg[hc];
        pmr_next[hc] = pmr_reg[hc];
        ps_next[hc] = ps_reg[hc];
    end

    // Register writes; a load write also arms a reload pulse
    if (bus_wr) begin
        case (bus_addr)
            `GTM_CFG: cfg_next = bus_wdata[2:0];
            `GTM_AMODE: mode_next[0] = bus_wdata[3:0];
            `GTM_BMODE: mode_next[1] = bus_wdata[3:0];
            `GTM_CTL: ctl_next = bus_wdata[15:0];
            `GTM_IMR: imr_next = bus_wdata[15:0];
            `GTM_ICR: st_clr = bus_wdata[15:0];
            `GTM_AILR: begin
                ilr_next[0] = bus_wdata[15:0];
                ilr_hi_next = bus_wdata[31:16];
                ld_next[0] = 1'b1;
            end
            `GTM_BILR: begin
                ilr_next[1] = bus_wdata[15:0];
                ld_next[1] = 1'b1;
            end
            `GTM_AMAT: begin
                mat_next[0] = bus_wdata[15:0];
                mat_hi_next = bus_wdata[31:16];
            end
            `GTM_BMAT: mat_next[1] = bus_wdata[15:0];
            `GTM_APR: pr_next[0] = bus_wdata[7:0];
            `GTM_BPR: pr_next[1] = bus_wdata[7:0];
            `GTM_APMR: pmr_next[0] = bus_wdata[7:0];
            `GTM_BPMR: pmr_next[1] = bus_wdata[7:0];
            default: ;
        endcase
    end

    // global configuration picks the counter layout
    if (cfg_reg == `GTM_CFG_RTC) begin
        en = ctl_reg[`GTM_CTL_EN];
        // override bit defeats both stall bits
        freeze = debug_halt & ~ctl_reg[`GTM_CTL_RTC_STALL_OVERRIDE] &
            (ctl_reg[`GTM_CTL_STALL] |
             ctl_reg[`GTM_STRIDE + `GTM_CTL_STALL]);
        if (!en) begin
            wide_cnt = `GTM_RTC_PRELOAD;
            rdiv_next = 16'h0000;
        end else if (!freeze &&
                edge_hit(`GTM_EV_RISE, sync2_reg[0], sync3_reg[0])) begin
            // pin clock divided down to seconds
            if (rdiv_reg == RTC_LAST) begin
                rdiv_next = 16'h0000;
                if (wide_cnt == wide_mat) begin
                    wide_cnt = 32'h00000000;
                    st_set[`GTM_ST_RTC] = 1'b1;
                end else begin
                    wide_cnt = wide_cnt + 32'h00000001;
                end
            end else begin
                rdiv_next = rdiv_reg + 16'h0001;
            end
        end
        cnt_next[0] = wide_cnt[15:0];
        cnt_hi_next = wide_cnt[31:16];
    end else if (cfg_reg == `GTM_CFG_W32) begin
        en = ctl_reg[`GTM_CTL_EN];
        stall = debug_halt & ctl_reg[`GTM_CTL_STALL];
        kind = half_kind(mode_reg[0]);
        if (!en || ld_reg[0]) begin
            wide_cnt = wide_ilr;
        end else if (!stall && kind == `GTM_K_TIMER) begin
            // mode field picks one-shot or periodic
            if (wide_cnt == 32'h00000000) begin
                wide_cnt = wide_ilr;
                st_set[`GTM_ST_TO] = 1'b1;
                if (mode_reg[0][1:0] == `GTM_MR_ONESHOT) begin
                    ctl_next[`GTM_CTL_EN] = 1'b0;
                end
            end else begin
                wide_cnt = wide_cnt - 32'h00000001;
            end
        end
        cnt_next[0] = wide_cnt[15:0];
        cnt_hi_next = wide_cnt[31:16];
    end else if (cfg_reg[2]) begin
        // Two independent 16-bit halves
        for (hc = 0; hc < 2; hc = hc + 1) begin
            kind = half_kind(mode_reg[hc]);
            en = ctl_reg[hc * `GTM_STRIDE + `GTM_CTL_EN];
            stall = debug_halt &
                ctl_reg[hc * `GTM_STRIDE + `GTM_CTL_STALL];
            edge_seen[hc] = edge_hit(
                ctl_reg[hc * `GTM_STRIDE + `GTM_CTL_EVT -: 2],
                sync2_reg[hc], sync3_reg[hc]);
            if (!en) begin
                // idle half waits at its load value
                cnt_next[hc] = ilr_reg[hc];
                ps_next[hc] = pr_reg[hc];
            end else if (kind == `GTM_K_ECNT) begin
                if (edge_seen[hc]) begin
                    if (cnt_reg[hc] - 16'h0001 == mat_reg[hc]) begin
                        // stop and reload at the match
                        cnt_next[hc] = ilr_reg[hc];
                        st_set[hc * `GTM_STRIDE + `GTM_ST_CM] = 1'b1;
                        ctl_next[hc * `GTM_STRIDE + `GTM_CTL_EN] = 1'b0;
                    end else begin
                        cnt_next[hc] = cnt_reg[hc] - 16'h0001;
                    end
                end
            end else if (ld_reg[hc]) begin
                // new interval one cycle after the write
                // new period one cycle after the write
                cnt_next[hc] = ilr_reg[hc];
                ps_next[hc] = pr_reg[hc];
            end else if (!stall && kind != `GTM_K_NONE) begin
                tick = (kind == `GTM_K_ETIME) || (ps_reg[hc] == 8'h00);
                if (kind != `GTM_K_ETIME) begin
                    ps_next[hc] = (ps_reg[hc] == 8'h00) ? pr_reg[hc] :
                        ps_reg[hc] - 8'h01;
                end
                if (tick) begin
                    // reload at zero and keep going; a one-shot timer stops
                    // PWM reloads the cycle after zero
                    if (cnt_reg[hc] == 16'h0000) begin
                        cnt_next[hc] = ilr_reg[hc];
                        if (kind == `GTM_K_TIMER) begin
                            st_set[hc * `GTM_STRIDE + `GTM_ST_TO] = 1'b1;
                        end
                        if (kind == `GTM_K_TIMER &&
                                mode_reg[hc][1:0] == `GTM_MR_ONESHOT) begin
                            ctl_next[hc * `GTM_STRIDE + `GTM_CTL_EN] =
                                1'b0;
                        end
                    end else begin
                        cnt_next[hc] = cnt_reg[hc] - 16'h0001;
                    end
                end
            end
            // held until the next selected edge
            if (en && kind == `GTM_K_ETIME && edge_seen[hc]) begin
                cap_next[hc] = cnt_reg[hc];
                st_set[hc * `GTM_STRIDE + `GTM_ST_CE] = 1'b1;
            end
            // on at the start value, off at the match
            if (en && kind == `GTM_K_PWM) begin
                if (cnt_next[hc] == ilr_reg[hc]) begin
                    lvl_next[hc] = 1'b1;
                end else if (cnt_next[hc] == mat_reg[hc]) begin
                    lvl_next[hc] = 1'b0;
                end else begin
                    lvl_next[hc] = lvl_reg[hc];
                end
            end
        end
    end

    // a set in the same cycle beats the clear
    ris_next = (ris_reg & ~st_clr) | st_set;

    // Read mux; unmapped offsets read as zero
    if (bus_rd) begin
        case (bus_addr)
            `GTM_CFG: rdata_next = {29'h0, cfg_reg};
            `GTM_AMODE: rdata_next = {28'h0, mode_reg[0]};
            `GTM_BMODE: rdata_next = {28'h0, mode_reg[1]};
            `GTM_CTL: rdata_next = {16'h0, ctl_reg};
            `GTM_IMR: rdata_next = {16'h0, imr_reg};
            `GTM_RIS: rdata_next = {16'h0, ris_reg};
            // masked flag follows raw and mask
            `GTM_MIS: rdata_next = {16'h0, ris_reg & imr_reg};
            `GTM_AILR: rdata_next = cfg_reg[2] ?
                {16'h0, ilr_reg[0]} : wide_ilr;
            `GTM_BILR: rdata_next = {16'h0, ilr_reg[1]};
            `GTM_AMAT: rdata_next = cfg_reg[2] ?
                {16'h0, mat_reg[0]} : wide_mat;
            `GTM_BMAT: rdata_next = {16'h0, mat_reg[1]};
            `GTM_APR: rdata_next = {24'h0, pr_reg[0]};
            `GTM_BPR: rdata_next = {24'h0, pr_reg[1]};
            `GTM_APMR: rdata_next = {24'h0, pmr_reg[0]};
            `GTM_BPMR: rdata_next = {24'h0, pmr_reg[1]};
            `GTM_AVAL: rdata_next = !cfg_reg[2] ?
                {cnt_hi_reg, cnt_reg[0]} :
                (half_kind(mode_reg[0]) == `GTM_K_ETIME) ?
                {16'h0, cap_reg[0]} : {16'h0, cnt_reg[0]};
            `GTM_BVAL: rdata_next =
                (half_kind(mode_reg[1]) == `GTM_K_ETIME) ?
                {16'h0, cap_reg[1]} : {16'h0, cnt_reg[1]};
            default: rdata_next = 32'h00000000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Registers

// All state and outputs update on the one clock edge
always @(posedge clock) begin
    if (reset) begin
        cfg_reg <= `GTM_CFG_W32;
        ctl_reg <= 16'h0000;
        imr_reg <= 16'h0000;
        ris_reg <= 16'h0000;
        ilr_hi_reg <= `GTM_LOAD_RST;
        mat_hi_reg <= `GTM_LOAD_RST;
        cnt_hi_reg <= `GTM_LOAD_RST;
        rdiv_reg <= 16'h0000;
        ld_reg <= 2'h0;
        lvl_reg <= 2'h0;
        bus_rdata <= 32'h00000000;
        pwm_a <= 1'b0;
        pwm_b <= 1'b0;
        for (hs = 0; hs < 2; hs = hs + 1) begin
            mode_reg[hs] <= 4'h0;
            ilr_reg[hs] <= `GTM_LOAD_RST;
            mat_reg[hs] <= `GTM_LOAD_RST;
            cnt_reg[hs] <= `GTM_LOAD_RST;
            cap_reg[hs] <= 16'h0000;
            pr_reg[hs] <= 8'h00;
            pmr_reg[hs] <= 8'h00;
            ps_reg[hs] <= 8'h00;
        end
    end else begin
        cfg_reg <= cfg_next;
        ctl_reg <= ctl_next;
        imr_reg <= imr_next;
        ris_reg <= ris_next;
        ilr_hi_reg <= ilr_hi_next;
        mat_hi_reg <= mat_hi_next;
        cnt_hi_reg <= cnt_hi_next;
        rdiv_reg <= rdiv_next;
        ld_reg <= ld_next;
        lvl_reg <= lvl_next;
        bus_rdata <= rdata_next;
        pwm_a <= lvl_next[0] ^ ctl_next[`GTM_CTL_PWML];
        pwm_b <= lvl_next[1] ^ ctl_next[`GTM_STRIDE + `GTM_CTL_PWML];
        for (hs = 0; hs < 2; hs = hs + 1) begin
            mode_reg[hs] <= mode_next[hs];
            ilr_reg[hs] <= ilr_next[hs];
            mat_reg[hs] <= mat_next[hs];
            cnt_reg[hs] <= cnt_next[hs];
            cap_reg[hs] <= cap_next[hs];
            pr_reg[hs] <= pr_next[hs];
            pmr_reg[hs] <= pmr_next[hs];
            ps_reg[hs] <= ps_next[hs];
        end
    end
end

endmodule

// ---- core/gtm_consts.vh ----
/*
 * Register offsets, field positions, reset values and counts for the
 * dual-half general timer.
 * Assumes byte addressing on a plain strobe port, one word a register.
 */
`ifndef GTM_CONSTS_VH
`define GTM_CONSTS_VH

// Register byte offsets
`define GTM_CFG 8'h00
`define GTM_AMODE 8'h04
`define GTM_BMODE 8'h08
`define GTM_CTL 8'h0C
`define GTM_IMR 8'h18
`define GTM_RIS 8'h1C
`define GTM_MIS 8'h20
`define GTM_ICR 8'h24
`define GTM_AILR 8'h28
`define GTM_BILR 8'h2C
`define GTM_AMAT 8'h30
`define GTM_BMAT 8'h34
`define GTM_APR 8'h38
`define GTM_BPR 8'h3C
`define GTM_APMR 8'h40
`define GTM_BPMR 8'h44
`define GTM_AVAL 8'h48
`define GTM_BVAL 8'h4C

// Global configuration codes
`define GTM_CFG_W32 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_H16 3'h4

// Mode field codes and half-mode bit positions
`define GTM_MR_ONESHOT 2'h1
`define GTM_MR_PERIODIC 2'h2
`define GTM_MR_CAPTURE 2'h3
`define GTM_MR_CMR 2
`define GTM_MR_AMS 3

// Half kinds decoded from the mode register
`define GTM_K_NONE 3'h0
`define GTM_K_TIMER 3'h1
`define GTM_K_PWM 3'h2
`define GTM_K_ETIME 3'h3
`define GTM_K_ECNT 3'h4

// Control bits; half B sits one stride above half A
`define GTM_STRIDE 8
`define GTM_CTL_EN 0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVT 3
`define GTM_CTL_RTC_STALL_OVERRIDE 4
`define GTM_CTL_PWML 6

// Event-type codes
`define GTM_EV_RISE 2'h0
`define GTM_EV_FALL 2'h1
`define GTM_EV_BOTH 2'h3

// Status bits; half B sits one stride above half A
`define GTM_ST_TO 0
`define GTM_ST_CM 1
`define GTM_ST_CE 2
`define GTM_ST_RTC 3

// Reset values and counts
`define GTM_LOAD_RST 16'hFFFF
`define GTM_RTC_PRELOAD 32'h00000001
`define GTM_RTC_DIV 32768

`endif

// ---- testbench/gtm_timer_asserts.sv ----
/* Checker for gtm_timer: read-back, flag masking, PWM shape.
   Assumes a half is disabled before it is reconfigured. */
`timescale 1ns/1ps
`include "gtm_consts.vh"
module gtm_timer_asserts (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register port
    input wire [7:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [31:0] bus_rdata,
    // Pins
    input wire ccp_a,
    input wire ccp_b,
    input wire debug_halt,
    input wire pwm_a,
    input wire pwm_b
);
    reg [2:0] cfg_sh;
    reg [3:0] amode_sh;
    reg [15:0] ctl_sh;
    reg [15:0] ld_sh;
    reg [15:0] mt_sh;
    reg [31:0] imr_sh;
    reg [31:0] age;
    reg [31:0] hi_cnt;
    reg [31:0] lo_cnt;
    wire touch;
    wire [15:0] duty_hi;
    wire pwm_on;
    wire pwm_run;

    ////////////////////////////////////////////////////////////////////
    // A write reshaping half A restarts the settle count
    assign touch = bus_wr && (bus_addr == `GTM_CFG
        || bus_addr == `GTM_AMODE || bus_addr == `GTM_CTL
        || bus_addr == `GTM_AILR || bus_addr == `GTM_AMAT);
    assign duty_hi = ld_sh - mt_sh;
    assign pwm_on = cfg_sh[2] && amode_sh == 4'hA && ctl_sh[0];
    // Judged only after two full periods; a load write bends one period
    assign pwm_run = pwm_on && !ctl_sh[6]
        && age > {15'h0, ld_sh, 1'b0} + 32'h4;

    // Shadow of what software last wrote
    always @(posedge clock) begin
        if (reset) begin
            cfg_sh <= 3'h0;
            amode_sh <= 4'h0;
            ctl_sh <= 16'h0;
            ld_sh <= 16'hFFFF;
            mt_sh <= 16'hFFFF;
            imr_sh <= 32'h0;
        end else if (bus_wr) begin
            case (bus_addr)
                `GTM_CFG: cfg_sh <= bus_wdata[2:0];
                `GTM_AMODE: amode_sh <= bus_wdata[3:0];
                `GTM_CTL: ctl_sh <= bus_wdata[15:0];
                `GTM_AILR: ld_sh <= bus_wdata[15:0];
                `GTM_AMAT: mt_sh <= bus_wdata[15:0];
                `GTM_IMR: imr_sh <= bus_wdata;
                default: ;
            endcase
        end
    end

    // Settle age and pulse-width counters
    always @(posedge clock) begin
        if (reset || touch) begin
            age <= 32'h0;
        end else begin
            age <= age + 32'h1;
        end
        if (reset) begin
            hi_cnt <= 32'h0;
            lo_cnt <= 32'h0;
        end else begin
            hi_cnt <= pwm_a ? hi_cnt + 32'h1 : 32'h0;
            lo_cnt <= pwm_a ? 32'h0 : lo_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_rd(a);
        bus_rd && bus_addr == a;
    endsequence

    a_icr_reads_zero: assert property (
        s_rd(`GTM_ICR) |=> bus_rdata == 32'h0)
        else $error("clear register read back nonzero");
    a_mis_masked: assert property (
        s_rd(`GTM_MIS) |=> (bus_rdata & ~imr_sh) == 32'h0)
        else $error("masked status shows an unmasked bit");
    a_cfg_readback: assert property (
        s_rd(`GTM_CFG) |=> bus_rdata == {29'h0, cfg_sh})
        else $error("configuration read back wrong");
    a_mode_readback: assert property (
        s_rd(`GTM_AMODE) |=> bus_rdata == {28'h0, amode_sh})
        else $error("half A mode read back wrong");
    a_reset_quiet: assert property (
        $fell(reset) |-> !pwm_a && !pwm_b && bus_rdata == 32'h0)
        else $error("outputs active after reset");
    a_pwm_no_flags: assert property (
        pwm_on and s_rd(`GTM_RIS) |=> bus_rdata[3:0] == 4'h0)
        else $error("status flag set in PWM mode");
    a_pwm_high_len: assert property (
        pwm_run && $fell(pwm_a) |-> hi_cnt == {16'h0, duty_hi})
        else $error("PWM high time wrong");
    a_pwm_low_len: assert property (
        pwm_run && $rose(pwm_a) |-> lo_cnt == {16'h0, mt_sh} + 32'h1)
        else $error("PWM low time wrong");
endmodule

bind gtm_timer gtm_timer_asserts chk (.clock(clock), .reset(reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ccp_a(ccp_a),
    .ccp_b(ccp_b), .debug_halt(debug_halt), .pwm_a(pwm_a),
    .pwm_b(pwm_b));

// ---- testbench/gtm_pin_src.sv ----
/* Capture-pin source standing in for external signals.
   Assumes the bench pulses a flip request for one cycle. */
`timescale 1ns/1ps
module gtm_pin_src (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Toggle requests
    input wire flip_a,
    input wire flip_b,
    // Capture pins
    output reg ccp_a,
    output reg ccp_b
);
    // Levels move only on the clock edge, so latency is repeatable
    always @(posedge clock) begin
        if (reset) begin
            ccp_a <= 1'b0;
            ccp_b <= 1'b0;
        end else begin
            ccp_a <= ccp_a ^ flip_a;
            ccp_b <= ccp_b ^ flip_b;
        end
    end
endmodule

// ---- testbench/gtm_timer_test.sv ----
/* Bench for gtm_timer: edge time, edge count, PWM, 32-bit timer.
   Assumes capture pins come from gtm_pin_src. */
`timescale 1ns/1ps
`include "gtm_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, g, e); \
    end end
module gtm_timer_test;
    localparam ALL = 32'hFFFFFFFF;
    reg clock;
    reg reset;
    reg [7:0] bus_addr;
    reg [31:0] bus_wdata;
    reg bus_wr;
    reg bus_rd;
    wire [31:0] bus_rdata;
    reg flip_a;
    reg flip_b;
    wire ccp_a;
    wire ccp_b;
    reg debug_halt;
    wire pwm_a;
    wire pwm_b;
    integer n_mismatch;
    integer cmp_count;
    reg [31:0] rv;

    gtm_timer uut (.clock(clock), .reset(reset), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .ccp_a(ccp_a), .ccp_b(ccp_b),
        .debug_halt(debug_halt), .pwm_a(pwm_a), .pwm_b(pwm_b));
    gtm_pin_src src (.clock(clock), .reset(reset), .flip_a(flip_a),
        .flip_b(flip_b), .ccp_a(ccp_a), .ccp_b(ccp_b));

    ////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task step(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // Strobe low for a cycle after each access, so no double drive
    task wr(input [7:0] a, input [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
        @(posedge clock);
    endtask
    task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        @(posedge clock);
        rv = bus_rdata;
        `CHK(rv & m, e)
    endtask
    task flip(input b);
        if (b)
            flip_b <= 1'b1;
        else
            flip_a <= 1'b1;
        @(posedge clock);
        flip_a <= 1'b0;
        flip_b <= 1'b0;
        @(posedge clock);
    endtask
    task wait_pwm(input v, output integer n);
        n = 0;
        while (pwm_a !== v) begin
            @(posedge clock);
            n = n + 1;
            if (n > 200) begin
                n_mismatch++;
                print_verdict;
            end
        end
    endtask
    task measure(input integer eh, input integer el);
        integer h;
        integer l;
        wait_pwm(1'b0, h);
        wait_pwm(1'b1, h);
        wait_pwm(1'b0, h);
        wait_pwm(1'b1, l);
        `CHK(h, eh)
        `CHK(l, el)
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_reset_vals;
        rdc(`GTM_CFG, ALL, 32'h0);
        rdc(`GTM_AMODE, ALL, 32'h0);
        rdc(`GTM_AILR, ALL, ALL);
        rdc(`GTM_BILR, ALL, 32'hFFFF);
        rdc(`GTM_BVAL, ALL, 32'hFFFF);
        rdc(`GTM_ICR, ALL, 32'h0);
        rdc(8'h50, ALL, 32'h0);
    endtask
    // Rising edges 40 cycles apart on a 49-count period
    task t_edge_time;
        reg [31:0] c1;
        wr(`GTM_CTL, 32'h0);
        wr(`GTM_CFG, 32'h4);
        wr(`GTM_AMODE, 32'h7);
        wr(`GTM_APR, 32'h5);
        wr(`GTM_AILR, 32'h30);
        wr(`GTM_IMR, 32'h4);
        wr(`GTM_ICR, ALL);
        wr(`GTM_CTL, 32'h1);
        flip(1'b0);
        step(6);
        rdc(`GTM_AVAL, ~32'h3F, 32'h0);
        c1 = rv;
        flip(1'b0);
        step(6);
        rdc(`GTM_AVAL, ALL, c1);
        rdc(`GTM_RIS, 32'h4, 32'h4);
        rdc(`GTM_MIS, 32'h4, 32'h4);
        wr(`GTM_ICR, 32'h0);
        rdc(`GTM_RIS, 32'h4, 32'h4);
        wr(`GTM_ICR, 32'h4);
        rdc(`GTM_RIS, 32'h4, 32'h0);
        step(8);
        flip(1'b0);
        step(6);
        rdc(`GTM_AVAL, ALL, (c1 + 32'd9) % 32'd49);
        wr(`GTM_AILR, 32'h10);
        flip(1'b0);
        step(4);
        flip(1'b0);
        step(6);
        rdc(`GTM_AVAL, ~32'h3F, 32'h0);
        `CHK(rv <= 32'h10, 1'b1)
    endtask
    // Pin starts high: one falling, one rising edge per kind
    task t_edge_kinds;
        integer k;
        reg [1:0] ev;
        for (k = 0; k < 3; k = k + 1) begin
            ev = (k == 2) ? 2'h3 : k[1:0];
            wr(`GTM_CTL, 32'h0);
            wr(`GTM_ICR, ALL);
            wr(`GTM_CTL, {28'h0, ev, 2'h1});
            flip(1'b0);
            step(4);
            rdc(`GTM_RIS, 32'h4, (ev != 2'h0) ? 32'h4 : 32'h0);
            wr(`GTM_ICR, 32'h4);
            flip(1'b0);
            step(4);
            rdc(`GTM_RIS, 32'h4, (ev != 2'h1) ? 32'h4 : 32'h0);
        end
    endtask
    // Load 0xA, match 6, both edges: four edges counted
    task t_edge_count;
        integer k;
        wr(`GTM_CTL, 32'h0);
        wr(`GTM_BMODE, 32'h3);
        wr(`GTM_BILR, 32'hA);
        wr(`GTM_BMAT, 32'h6);
        wr(`GTM_ICR, ALL);
        wr(`GTM_CTL, 32'h0D00);
        for (k = 0; k < 3; k = k + 1) begin
            flip(1'b1);
            step(3);
        end
        rdc(`GTM_BVAL, ALL, 32'h7);
        rdc(`GTM_RIS, 32'h200, 32'h0);
        flip(1'b1);
        step(4);
        rdc(`GTM_RIS, 32'h200, 32'h200);
        rdc(`GTM_CTL, 32'h100, 32'h0);
        flip(1'b1);
        step(3);
        flip(1'b1);
        step(4);
        rdc(`GTM_BVAL, ALL, 32'hA);
    endtask
    task t_pwm;
        wr(`GTM_CTL, 32'h0);
        wr(`GTM_AMODE, 32'hA);
        wr(`GTM_AILR, 32'h9);
        wr(`GTM_AMAT, 32'h3);
        wr(`GTM_APR, 32'h0);
        wr(`GTM_ICR, ALL);
        wr(`GTM_CTL, 32'h1);
        step(30);
        measure(6, 4);
        rdc(`GTM_RIS, 32'hF, 32'h0);
        wr(`GTM_CTL, 32'h0);
        wr(`GTM_CTL, 32'h41);
        measure(4, 6);
        wr(`GTM_AILR, 32'h5);
        measure(4, 2);
    endtask
    task t_timer32;
        integer m;
        for (m = 1; m < 3; m = m + 1) begin
            wr(`GTM_CTL, 32'h0);
            wr(`GTM_CFG, 32'h0);
            wr(`GTM_AMODE, m);
            wr(`GTM_AILR, 32'd20);
            wr(`GTM_ICR, ALL);
            wr(`GTM_CTL, 32'h1);
            step(40);
            rdc(`GTM_RIS, 32'h1, 32'h1);
            rdc(`GTM_CTL, 32'h1, (m == 2) ? 32'h1 : 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        bus_addr = 8'h0;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        flip_a = 1'b0;
        flip_b = 1'b0;
        debug_halt = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset_vals;
        t_edge_time;
        t_edge_kinds;
        t_edge_count;
        t_pwm;
        t_timer32;
        print_verdict;
    end
endmodule
